// *** core/cfb_top.sv ***
// Configurable function block: selector, add, max/min, counter, mul/div
`include "cfb_cfg.svh"
`default_nettype none

module cfb_top
    import cfb_pkg::*;
#(
    parameter int TICK_CYC = `CFB_TICK_CYC
)
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // Register port
    input  wire logic [`CFB_AW-1:0]   addr,
    input  wire logic [`CFB_DW-1:0]   wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [`CFB_DW-1:0]   rdata,
    // Results to linked parameters
    output logic      [`CFB_DW-1:0]   result_word_1,
    output logic      [`CFB_DW-1:0]   result_word_2
);

    ////////////////////////////////////////////////////////////////////////
    // Control and operand registers

    logic [`CFB_DW-1:0] ctrl_reg;
    logic [`CFB_DW-1:0] opnd_reg [1:7];
    logic [7:1]         truth;
    cfb_func_t          func;
    logic               pu_mode;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            ctrl_reg <= `CFB_CTRL_RST;
        else if (wr && addr == `CFB_ADDR_CTRL)
            ctrl_reg <= wdata;
    end

    // Unknown codes fall back to off so two functions never share operands
    always_comb
    begin
        case (ctrl_reg[`CFB_CTRL_FUNC_MSB:`CFB_CTRL_FUNC_LSB])
            3'h1:    func = CFB_F_SEL;
            3'h2:    func = CFB_F_ADD;
            3'h3:    func = CFB_F_MAXMIN;
            3'h4:    func = CFB_F_COUNT;
            3'h5:    func = CFB_F_MULDIV;
            default: func = CFB_F_OFF;
        endcase
    end
    assign pu_mode = ctrl_reg[`CFB_CTRL_PU_BIT];

    genvar gi;
    generate
        for (gi = 1; gi <= 7; gi++)
        begin : g_opnd
            always_ff @(posedge clk)
            begin
                if (!rstn)
                    opnd_reg[gi] <= `CFB_OP_RST;
                else if (wr && addr == `CFB_ADDR_OP_BASE + 4'(gi - 1))
                    opnd_reg[gi] <= wdata;
            end
            assign truth[gi] = |opnd_reg[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Tick divider and on-delay timer

    logic [15:0] tick_cnt_reg;
    logic        tick;
    logic [15:0] delay_cnt_reg;
    logic        delay_done;

    always_ff @(posedge clk)
    begin
        if (!rstn || tick_cnt_reg == 16'(TICK_CYC - 1))
            tick_cnt_reg <= 16'h0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
    assign tick = (tick_cnt_reg == 16'(TICK_CYC - 1));

    assign delay_done = (delay_cnt_reg >= opnd_reg[5]);

    // Timer restarts whenever operand_1 drops
    always_ff @(posedge clk)
    begin
        if (!rstn || func != CFB_F_SEL || !truth[1])
            delay_cnt_reg <= 16'h0000;
        else if (tick && !delay_done)
            delay_cnt_reg <= delay_cnt_reg + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Up/down counter

    logic [31:0] cnt_reg;
    logic        up_prev_reg;
    logic        dn_prev_reg;
    logic        up_edge;
    logic        dn_edge;
    logic [31:0] cnt_next;
    logic [31:0] load_val;

    assign up_edge  = truth[1] && !up_prev_reg;
    assign dn_edge  = truth[2] && !dn_prev_reg;
    assign load_val = {{16{opnd_reg[7][15]}}, opnd_reg[7]};

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            up_prev_reg <= 1'b0;
            dn_prev_reg <= 1'b0;
        end
        else
        begin
            up_prev_reg <= truth[1];
            dn_prev_reg <= truth[2];
        end
    end

    always_comb
    begin
        cnt_next = cnt_reg;
        if (truth[3])
            cnt_next = load_val;
        else
        begin
            if (up_edge)
                cnt_next = cnt_next + {{16{opnd_reg[4][15]}}, opnd_reg[4]};
            if (dn_edge)
                cnt_next = cnt_next - {{16{opnd_reg[5][15]}}, opnd_reg[5]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            cnt_reg <= 32'h0000_0000;
        else if (func == CFB_F_COUNT)
            cnt_reg <= cnt_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiply/divide datapath

    logic signed [31:0] prod;
    logic signed [47:0] dividend;
    logic signed [47:0] quot;
    logic               div_zero;

    assign prod     = $signed(opnd_reg[1]) * $signed(opnd_reg[2]);
    // Per-unit scales by 65536 so 4096 x 4096 / 4096 gives a whole of 4096
    assign dividend = pu_mode ? {prod, 16'h0000} : {{16{prod[31]}}, prod};
    assign div_zero = !truth[3];
    // Both arms signed, else the divide falls back to unsigned
    assign quot     = div_zero ? 48'sh0000_0000_0000
                               : dividend / $signed({{32{opnd_reg[3][15]}}, opnd_reg[3]});

    ////////////////////////////////////////////////////////////////////////
    // Result selection

    cfb_res_t res_reg;
    cfb_res_t res_next;
    logic     divz_reg;

    always_comb
    begin
        res_next = res_reg;
        case (func)
            CFB_F_SEL:
            begin
                if (truth[1])
                begin
                    if (delay_done)
                        res_next.word_1 = opnd_reg[4];
                end
                else if (truth[2])
                    res_next.word_1 = opnd_reg[7];
                else
                    res_next.word_1 = opnd_reg[3];
            end
            CFB_F_ADD:
                res_next.word_1 = opnd_reg[1] + opnd_reg[2];
            CFB_F_MAXMIN:
            begin
                if (($signed(opnd_reg[1]) > $signed(opnd_reg[2])) == truth[3])
                    res_next.word_1 = opnd_reg[1];
                else
                    res_next.word_1 = opnd_reg[2];
            end
            CFB_F_COUNT:
            begin
                if (truth[6])
                begin
                    res_next.word_1 = cnt_reg[31:16];
                    res_next.word_2 = cnt_reg[15:0];
                end
                else
                    res_next.word_1 = cnt_reg[15:0];
            end
            CFB_F_MULDIV:
            begin
                if (!div_zero)
                begin
                    if (pu_mode)
                    begin
                        res_next.word_1 = quot[31:16];
                        res_next.word_2 = quot[15:0];
                    end
                    else
                    begin
                        res_next.word_1 = quot[15:0];
                        res_next.word_2 = quot[31:16];
                    end
                end
            end
            default:
                res_next = res_reg;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            res_reg <= '0;
        else
            res_reg <= res_next;
    end

    // Sticky until leaving mul/div or a valid divisor arrives
    always_ff @(posedge clk)
    begin
        if (!rstn)
            divz_reg <= 1'b0;
        else
            divz_reg <= (func == CFB_F_MULDIV) && div_zero;
    end

    assign result_word_1 = res_reg.word_1;
    assign result_word_2 = res_reg.word_2;

    ////////////////////////////////////////////////////////////////////////
    // Read port

    logic [`CFB_DW-1:0] rd_mux;

    always_comb
    begin
        rd_mux = 16'h0000;
        if (addr == `CFB_ADDR_CTRL)
            rd_mux = ctrl_reg;
        else if (addr >= `CFB_ADDR_OP_BASE && addr < `CFB_ADDR_RES1)
            rd_mux = opnd_reg[addr[2:0]];
        else if (addr == `CFB_ADDR_RES1)
            rd_mux = res_reg.word_1;
        else if (addr == `CFB_ADDR_RES2)
            rd_mux = res_reg.word_2;
        else if (addr == `CFB_ADDR_STAT)
        begin
            rd_mux[`CFB_STAT_DIVZ]  = divz_reg;
            rd_mux[`CFB_STAT_TRUN]  = (func == CFB_F_SEL) && truth[1] && !delay_done;
            rd_mux[`CFB_STAT_TDONE] = (func == CFB_F_SEL) && truth[1] && delay_done;
            rd_mux[`CFB_STAT_CHOLD] = (func == CFB_F_COUNT) && truth[3];
        end
    end

    // Reads of unmapped addresses return zero
    always_ff @(posedge clk)
    begin
        if (!rstn)
            rdata <= 16'h0000;
        else if (rd)
            rdata <= rd_mux;
        else
            rdata <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_cnt_load;
        func == CFB_F_COUNT && truth[3];
    endsequence

    sequence s_cnt_held;
        s_cnt_load ##1 s_cnt_load;
    endsequence

    a_add_sum_out: assert property
        (func == CFB_F_ADD |=> res_reg.word_1 == $past(opnd_reg[1] + opnd_reg[2]))
        else $error("add result wrong");

    a_maxmin_pick: assert property
        (func == CFB_F_MAXMIN && !truth[3] |=>
            $signed(res_reg.word_1) == ($signed($past(opnd_reg[1])) < $signed($past(opnd_reg[2]))
            ? $signed($past(opnd_reg[1])) : $signed($past(opnd_reg[2]))))
        else $error("min select wrong");

    a_sel_idle_out: assert property
        (func == CFB_F_SEL && !truth[1] && !truth[2] |=> res_reg.word_1 == $past(opnd_reg[3]))
        else $error("selector idle value wrong");

    a_sel_second_in: assert property
        (func == CFB_F_SEL && !truth[1] && truth[2] |=> res_reg.word_1 == $past(opnd_reg[7]))
        else $error("selector operand_7 not shown");

    a_sel_delay_hold: assert property
        (func == CFB_F_SEL && truth[1] && !delay_done |=> $stable(res_reg.word_1))
        else $error("selector changed before delay");

    a_cnt_held_load: assert property
        (s_cnt_held |-> cnt_reg == $past(load_val))
        else $error("counter not held at load");

    a_cnt_both_edges: assert property
        (func == CFB_F_COUNT && !truth[3] |=>
            cnt_reg == $past(cnt_reg)
                       + ($past(up_edge) ? {{16{$past(opnd_reg[4][15])}}, $past(opnd_reg[4])}
                                         : 32'h0000_0000)
                       - ($past(dn_edge) ? {{16{$past(opnd_reg[5][15])}}, $past(opnd_reg[5])}
                                         : 32'h0000_0000))
        else $error("counter edge step wrong");

    a_cnt_single_word: assert property
        (func == CFB_F_COUNT && !truth[6] |=> res_reg.word_1 == $past(cnt_reg[15:0]))
        else $error("counter word wrong");

    a_div_zero_hold: assert property
        (func == CFB_F_MULDIV && !truth[3] |=> $stable(res_reg) && divz_reg)
        else $error("result moved on zero divisor");

endmodule // cfb_top

`default_nettype wire

// *** core/cfb_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the function block
`ifndef CFB_CFG_SVH
`define CFB_CFG_SVH

`define CFB_AW            4
`define CFB_DW            16
`define CFB_ADDR_CTRL     4'h0
`define CFB_ADDR_OP_BASE  4'h1
`define CFB_ADDR_RES1     4'h8
`define CFB_ADDR_RES2     4'h9
`define CFB_ADDR_STAT     4'hA
`define CFB_CTRL_FUNC_LSB 0
`define CFB_CTRL_FUNC_MSB 2
`define CFB_CTRL_PU_BIT   3
`define CFB_CTRL_RST      16'h0000
`define CFB_OP_RST        16'h0000
`define CFB_STAT_DIVZ     0
`define CFB_STAT_TRUN     1
`define CFB_STAT_TDONE    2
`define CFB_STAT_CHOLD    3
`define CFB_CLK_KHZ       40000
`define CFB_TICK_US       1000
`define CFB_TICK_CYC      ((`CFB_TICK_US * `CFB_CLK_KHZ) / 1000)

`endif

// *** core/cfb_pkg.sv ***
// Types shared by the function block
`default_nettype none
package cfb_pkg;
    typedef enum logic [2:0]
    {
        CFB_F_OFF,
        CFB_F_SEL,
        CFB_F_ADD,
        CFB_F_MAXMIN,
        CFB_F_COUNT,
        CFB_F_MULDIV
    } cfb_func_t;

    typedef struct packed
    {
        logic [15:0] word_1;
        logic [15:0] word_2;
    } cfb_res_t;
endpackage
`default_nettype wire

// *** tb/cfb_link_model.sv ***
// Drive parameter link model: writes operand words and reads back words
`default_nettype none

module cfb_link_model
(
    // Clock
    input  wire logic        clk,
    // Register port toward the block
    output var  logic [3:0]  addr,
    output var  logic [15:0] wdata,
    output var  logic        wr,
    output var  logic        rd,
    input  wire logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        addr  = 4'h0;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    task automatic put(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        // Stale data must not look valid after the strobe
        wdata <= ~d;
    endtask

    task automatic get(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        // Read word stands only in the cycle after the strobe
        @(negedge clk);
        d = rdata;
    endtask
endmodule // cfb_link_model
`default_nettype wire

// *** tb/cfb_top_tb.sv ***
// Self-checking bench of the function block against an integer model
`default_nettype none

module cfb_top_tb
    import cfb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rstn;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic [15:0] res1;
    logic [15:0] res2;
    logic [15:0] op [1:7];
    int          error_cnt = 0;
    int          samples_checked = 0;
    integer      seed = 32'hA00909D9;

    ////////////////////////////////////////////////////////////////////////
    cfb_top #(.TICK_CYC(4)) i_dut
    (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .result_word_1(res1), .result_word_2(res2)
    );

    cfb_link_model i_link
    (
        .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic w(input int i, input logic [15:0] v);
        i_link.put(4'(i), v);
        op[i] = v;
    endtask

    task automatic ctl(input cfb_func_t f, input logic pu);
        i_link.put(4'h0, {12'h000, pu, f});
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        i_link.get(a, d);
        chk(d, e);
    endtask

    // Result lands one edge after the write, counter two
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("ERROR %0t: run did not finish", $time);
        wrap_up();
    end

    initial
    begin
        int          cnt;
        longint      q;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk(res1, 16'h0000);
        chk(res2, 16'h0000);
        rdchk(4'h0, 16'h0000);
        rdchk(4'hB, 16'h0000);
        i_link.put(4'h8, 16'h1234);
        rdchk(4'h8, 16'h0000);
        // Add with random operands, wrapping at 16 bits
        ctl(CFB_F_ADD, 1'b0);
        for (int k = 0; k < 6; k++)
        begin
            w(1, 16'($random(seed)));
            w(2, 16'($random(seed)));
            settle();
            chk(res1, op[1] + op[2]);
            rdchk(4'h1, op[1]);
        end
        // Max/min, condition true on a word with only the sign bit set
        ctl(CFB_F_MAXMIN, 1'b0);
        for (int k = 0; k < 6; k++)
        begin
            a = 16'($random(seed));
            b = 16'($random(seed));
            w(1, a);
            w(2, b);
            w(3, (k % 2) ? 16'h8000 : 16'h0000);
            settle();
            chk(res1, ((k % 2) ^ ($signed(a) < $signed(b))) ? a : b);
        end
        // Counter: load, hold against edges, then count past 16 bits
        ctl(CFB_F_COUNT, 1'b0);
        w(1, 16'h0000);
        w(2, 16'h0000);
        w(4, 16'h7FFF);
        w(5, 16'h0003);
        w(6, 16'h0000);
        w(7, 16'hFFF0);
        w(3, 16'h0001);
        w(1, 16'h0100);
        w(2, 16'h0100);
        settle();
        chk(res1, 16'hFFF0);
        rdchk(4'hA, 16'h0008);
        w(1, 16'h0000);
        w(2, 16'h0000);
        w(3, 16'h0000);
        cnt = -16;
        for (int k = 0; k < 3; k++)
        begin
            w(1, 16'h0100);
            w(1, 16'h0000);
            cnt = cnt + $signed(op[4]);
        end
        w(2, 16'h0001);
        cnt = cnt - $signed(op[5]);
        settle();
        chk(res1, cnt[15:0]);
        w(6, 16'h0001);
        settle();
        chk(res1, cnt[31:16]);
        chk(res2, cnt[15:0]);
        // Multiply/divide in standard math
        ctl(CFB_F_MULDIV, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            a = 16'($random(seed));
            b = 16'($random(seed));
            c = 16'($random(seed)) | 16'h0001;
            w(1, a);
            w(2, b);
            w(3, c);
            settle();
            q = (longint'($signed(a)) * $signed(b)) / $signed(c);
            chk(res1, q[15:0]);
            chk(res2, q[31:16]);
        end
        // Per-unit math, then a zero divisor must hold the result
        w(1, 16'd199);
        w(2, 16'd8192);
        w(3, 16'd100);
        ctl(CFB_F_MULDIV, 1'b1);
        settle();
        q = (longint'(199) * 8192 * 65536) / 100;
        chk(res1, q[31:16]);
        chk(res2, q[15:0]);
        w(3, 16'h0000);
        settle();
        chk(res1, q[31:16]);
        chk(res2, q[15:0]);
        rdchk(4'hA, 16'h0001);
        // State selector with a two-tick on-delay
        ctl(CFB_F_SEL, 1'b0);
        w(1, 16'h0000);
        w(2, 16'h0000);
        w(3, 16'h1111);
        w(4, 16'h4444);
        w(5, 16'h0002);
        w(7, 16'h7777);
        settle();
        chk(res1, 16'h1111);
        w(2, 16'h0020);
        settle();
        chk(res1, 16'h7777);
        w(1, 16'h0001);
        settle();
        chk(res1, 16'h7777);
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk(res1, 16'h4444);
        rdchk(4'hA, 16'h0004);
        w(1, 16'h0000);
        settle();
        chk(res1, 16'h7777);
        w(2, 16'h0000);
        settle();
        chk(res1, 16'h1111);
        // Function off keeps the last result
        ctl(CFB_F_OFF, 1'b0);
        w(3, 16'h2222);
        settle();
        chk(res1, 16'h1111);
        wrap_up();
    end
endmodule // cfb_top_tb
`default_nettype wire
